/* rtl/bit_flag_load_exec.sv */
// Execution unit for flag branches, I/O bit ops, shifts, flag ops and indirect loads
`default_nettype none

module bit_flag_load_exec
  import bit_flag_load_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              resetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output logic [15:0]            memAddr,
  output logic                   memRdEn,
  input  wire logic [7:0]        memRdData,
  output logic                   busy
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    state_t             st;
    logic [31:0][7:0]   wr;
    logic [31:0][7:0]   io;
    logic [7:0]         flags;
    logic [15:0]        pc;
    cmd_t               cmd;
    logic [15:0]        memAddr;
    logic               memRdEn;
    logic               awHeld;
    logic [ADDR_W-1:0]  awAddr;
    logic               wHeld;
    logic [31:0]        wData;
    logic [3:0]         wStrb;
    logic               bValid;
    logic [1:0]         bResp;
    logic               rValid;
    logic [31:0]        rData;
    logic [1:0]         rResp;
  } core_t;

  core_t core_r;
  core_t core_nxt;

  logic [7:0] shRes;
  logic       shC;
  logic       shZ;
  logic       shN;
  logic       shV;

  shift_unit u_shift (
    .opc      (core_r.cmd.opc),
    .val      (core_r.wr[core_r.cmd.rd]),
    .carryIn  (core_r.flags[FLAG_C]),
    .res      (shRes),
    .carryOut (shC),
    .zeroOut  (shZ),
    .negOut   (shN),
    .ovfOut   (shV)
  );

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] mergeStrb(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        m[i*8 +: 8] = nw[i*8 +: 8];
    return m;
  endfunction

  function automatic logic [4:0] ptrLo(input logic [1:0] sel);
    logic [1:0] s;
    s = (sel == 2'h3) ? PTR_Z : sel;
    return PTR_LO_BASE + {2'b00, s, 1'b0};
  endfunction

  logic [4:0]  wIdx;
  logic [4:0]  rIdx;
  logic [4:0]  awRegion;
  logic [4:0]  arRegion;
  logic [4:0]  curLo;
  logic [15:0] curPtr;
  logic [15:0] branchDest;
  logic        branchTaken;

  assign wIdx     = core_r.awAddr[INDEX_LSB +: 5];
  assign awRegion = core_r.awAddr[ADDR_W-1:REGION_LSB];
  assign rIdx     = araddr[INDEX_LSB +: 5];
  assign arRegion = araddr[ADDR_W-1:REGION_LSB];
  assign curLo    = ptrLo(core_r.cmd.ptrSel);
  assign curPtr   = {core_r.wr[curLo + 5'h01], core_r.wr[curLo]};

  assign branchTaken = core_r.flags[FLAG_I] == (core_r.cmd.opc == OPC_BR_IRQ_ON);
  assign branchDest  = core_r.pc + {{9{core_r.cmd.offsetK[6]}}, core_r.cmd.offsetK} + 16'h0001;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    cmd_t        nc;
    logic [4:0]  lo;
    logic [15:0] ptr;
    logic [15:0] ea;
    nc  = core_r.cmd;
    lo  = 5'h00;
    ptr = 16'h0000;
    ea  = 16'h0000;
    core_nxt = core_r;

    // Bus write channels held until both halves are in
    if (awvalid && awready)
    begin
      core_nxt.awHeld = 1'b1;
      core_nxt.awAddr = awaddr;
    end
    if (wvalid && wready)
    begin
      core_nxt.wHeld = 1'b1;
      core_nxt.wData = wdata;
      core_nxt.wStrb = wstrb;
    end
    if (bvalid && bready)
      core_nxt.bValid = 1'b0;
    if (core_r.awHeld && core_r.wHeld && !core_r.bValid)
    begin
      core_nxt.awHeld = 1'b0;
      core_nxt.wHeld  = 1'b0;
      core_nxt.bValid = 1'b1;
      core_nxt.bResp  = RESP_OKAY;
      if (core_r.awAddr == CMD_ADDR)
      begin
        // Commands while busy are dropped
        if (core_r.st == ST_IDLE)
        begin
          nc = cmd_t'(mergeStrb(32'(core_r.cmd), core_r.wData, core_r.wStrb));
          core_nxt.cmd = nc;
          core_nxt.st  = ST_EXEC1;
          lo  = ptrLo(nc.ptrSel);
          ptr = {core_r.wr[lo + 5'h01], core_r.wr[lo]};
          unique case (nc.mode)
            MODE_PREDEC: ea = ptr - 16'h0001;
            MODE_DISP:   ea = (nc.ptrSel == PTR_X) ? ptr : ptr + {10'h000, nc.dispQ};
            default:     ea = ptr;
          endcase
          core_nxt.memAddr = ea;
          core_nxt.memRdEn = (nc.opc == OPC_LOAD);
        end
      end
      else if (core_r.awAddr == FLAGS_ADDR)
      begin
        if (core_r.wStrb[0])
          core_nxt.flags = core_r.wData[7:0];
      end
      else if (core_r.awAddr == PC_ADDR)
        core_nxt.pc = 16'(mergeStrb({16'h0000, core_r.pc}, core_r.wData, core_r.wStrb));
      else if (awRegion == WREG_REGION && core_r.awAddr[1:0] == 2'b00)
      begin
        if (core_r.wStrb[0])
          core_nxt.wr[wIdx] = core_r.wData[7:0];
      end
      else if (awRegion == IO_REGION && core_r.awAddr[1:0] == 2'b00)
      begin
        if (core_r.wStrb[0])
          core_nxt.io[wIdx] = core_r.wData[7:0];
      end
      else if (core_r.awAddr != STATUS_ADDR)
        core_nxt.bResp = RESP_SLVERR;
    end

    // Bus read channel, one word per request
    if (arvalid && arready)
    begin
      core_nxt.rValid = 1'b1;
      core_nxt.rResp  = RESP_OKAY;
      core_nxt.rData  = 32'h0000_0000;
      if (araddr == CMD_ADDR)
        core_nxt.rData = 32'(core_r.cmd);
      else if (araddr == STATUS_ADDR)
      begin
        core_nxt.rData[BUSY_BIT]           = (core_r.st != ST_IDLE);
        core_nxt.rData[FLAGS_LSB +: 8]     = core_r.flags;
      end
      else if (araddr == FLAGS_ADDR)
        core_nxt.rData[7:0] = core_r.flags;
      else if (araddr == PC_ADDR)
        core_nxt.rData[15:0] = core_r.pc;
      else if (arRegion == WREG_REGION && araddr[1:0] == 2'b00)
        core_nxt.rData[7:0] = core_r.wr[rIdx];
      else if (arRegion == IO_REGION && araddr[1:0] == 2'b00)
        core_nxt.rData[7:0] = core_r.io[rIdx];
      else
        core_nxt.rResp = RESP_SLVERR;
    end
    else if (rvalid && rready)
      core_nxt.rValid = 1'b0;

    // Execution sequence, after the bus so it wins on overlap
    unique case (core_r.st)
      ST_IDLE:
      begin
      end
      ST_EXEC1:
      begin
        core_nxt.memRdEn = 1'b0;
        core_nxt.st      = ST_IDLE;
        core_nxt.pc      = core_r.pc + 16'h0001;
        unique case (core_r.cmd.opc)
          OPC_BR_IRQ_ON, OPC_BR_IRQ_OFF:
          begin
            if (branchTaken)
            begin
              core_nxt.pc = branchDest;
              core_nxt.st = ST_EXEC2;
            end
          end
          OPC_IO_SET, OPC_IO_CLEAR:
          begin
            core_nxt.pc = core_r.pc;
            core_nxt.st = ST_EXEC2;
          end
          OPC_SHL, OPC_SHR, OPC_ROTL, OPC_ROTR, OPC_ASHR:
          begin
            core_nxt.wr[core_r.cmd.rd]  = shRes;
            core_nxt.flags[FLAG_C]      = shC;
            core_nxt.flags[FLAG_Z]      = shZ;
            core_nxt.flags[FLAG_N]      = shN;
            core_nxt.flags[FLAG_V]      = shV;
          end
          OPC_BIT_TO_T: core_nxt.flags[FLAG_T] = core_r.wr[core_r.cmd.rd][core_r.cmd.bitSel];
          OPC_T_TO_BIT: core_nxt.wr[core_r.cmd.rd][core_r.cmd.bitSel] = core_r.flags[FLAG_T];
          OPC_FLAG_ONE:  core_nxt.flags[core_r.cmd.bitSel] = 1'b1;
          OPC_FLAG_ZERO: core_nxt.flags[core_r.cmd.bitSel] = 1'b0;
          OPC_LOAD:
          begin
            core_nxt.pc = core_r.pc;
            core_nxt.st = ST_EXEC2;
            if (core_r.cmd.mode == MODE_POSTINC)
              {core_nxt.wr[curLo + 5'h01], core_nxt.wr[curLo]} = curPtr + 16'h0001;
            else if (core_r.cmd.mode == MODE_PREDEC)
              {core_nxt.wr[curLo + 5'h01], core_nxt.wr[curLo]} = curPtr - 16'h0001;
          end
          default:
          begin
          end
        endcase
      end
      ST_EXEC2:
      begin
        core_nxt.st = ST_IDLE;
        unique case (core_r.cmd.opc)
          OPC_IO_SET:
          begin
            core_nxt.io[core_r.cmd.rd][core_r.cmd.bitSel] = 1'b1;
            core_nxt.pc = core_r.pc + 16'h0001;
          end
          OPC_IO_CLEAR:
          begin
            core_nxt.io[core_r.cmd.rd][core_r.cmd.bitSel] = 1'b0;
            core_nxt.pc = core_r.pc + 16'h0001;
          end
          OPC_LOAD:
          begin
            core_nxt.wr[core_r.cmd.rd] = memRdData;
            core_nxt.pc = core_r.pc + 16'h0001;
          end
          default:
          begin
          end
        endcase
      end
      default: core_nxt.st = ST_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge resetn)
  begin
    if (!resetn)
    begin
      core_r        <= '0;
      core_r.st     <= ST_IDLE;
      core_r.flags  <= FLAGS_RESET;
      core_r.pc     <= PC_RESET;
      core_r.wr     <= {32{WREG_RESET}};
      core_r.bResp  <= RESP_OKAY;
      core_r.rResp  <= RESP_OKAY;
    end
    else
      core_r <= core_nxt;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign awready = !core_r.awHeld && !core_r.bValid;
  assign wready  = !core_r.wHeld && !core_r.bValid;
  assign bvalid  = core_r.bValid;
  assign bresp   = core_r.bResp;
  assign arready = !core_r.rValid;
  assign rvalid  = core_r.rValid;
  assign rdata   = core_r.rData;
  assign rresp   = core_r.rResp;
  assign memAddr = core_r.memAddr;
  assign memRdEn = core_r.memRdEn;
  assign busy    = (core_r.st != ST_IDLE);

endmodule

`default_nettype wire

/* shared/bit_flag_load_pkg.sv */
// Constants, command layout and register map of the bit, flag and load execution unit
`default_nettype none

package bit_flag_load_pkg;

  // ----------------------------------------------------------------
  // Bus and register map
  // ----------------------------------------------------------------
  localparam int          ADDR_W       = 12;
  localparam int          REGION_LSB   = 7;
  localparam int          INDEX_LSB    = 2;
  localparam logic [11:0] CMD_ADDR     = 12'h000;
  localparam logic [11:0] STATUS_ADDR  = 12'h004;
  localparam logic [11:0] FLAGS_ADDR   = 12'h008;
  localparam logic [11:0] PC_ADDR      = 12'h00C;
  localparam logic [4:0]  WREG_REGION  = 5'h02;
  localparam logic [4:0]  IO_REGION    = 5'h03;
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;
  localparam int          BUSY_BIT     = 0;
  localparam int          FLAGS_LSB    = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]  FLAGS_RESET  = 8'h00;
  localparam logic [15:0] PC_RESET     = 16'h0000;
  localparam logic [7:0]  WREG_RESET   = 8'h00;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLAG_C = 3'h0;
  localparam logic [2:0] FLAG_Z = 3'h1;
  localparam logic [2:0] FLAG_N = 3'h2;
  localparam logic [2:0] FLAG_V = 3'h3;
  localparam logic [2:0] FLAG_S = 3'h4;
  localparam logic [2:0] FLAG_H = 3'h5;
  localparam logic [2:0] FLAG_T = 3'h6;
  localparam logic [2:0] FLAG_I = 3'h7;

  // ----------------------------------------------------------------
  // Pointer pairs and load modes
  // ----------------------------------------------------------------
  localparam logic [4:0] PTR_LO_BASE  = 5'h1A;
  localparam logic [1:0] PTR_X        = 2'h0;
  localparam logic [1:0] PTR_Y        = 2'h1;
  localparam logic [1:0] PTR_Z        = 2'h2;
  localparam logic [1:0] MODE_PLAIN   = 2'h0;
  localparam logic [1:0] MODE_POSTINC = 2'h1;
  localparam logic [1:0] MODE_PREDEC  = 2'h2;
  localparam logic [1:0] MODE_DISP    = 2'h3;

  typedef enum logic [4:0] {
    OPC_NOP         = 5'h00,
    OPC_BR_IRQ_ON   = 5'h01,
    OPC_BR_IRQ_OFF  = 5'h02,
    OPC_IO_SET      = 5'h03,
    OPC_IO_CLEAR    = 5'h04,
    OPC_SHL         = 5'h05,
    OPC_SHR         = 5'h06,
    OPC_ROTL        = 5'h07,
    OPC_ROTR        = 5'h08,
    OPC_ASHR        = 5'h09,
    OPC_BIT_TO_T    = 5'h0A,
    OPC_T_TO_BIT    = 5'h0B,
    OPC_FLAG_ONE    = 5'h0C,
    OPC_FLAG_ZERO   = 5'h0D,
    OPC_LOAD        = 5'h0E
  } opc_t;

  typedef struct packed {
    logic       spareHi;
    logic [6:0] offsetK;
    logic       spareLo;
    logic [5:0] dispQ;
    logic [1:0] mode;
    logic [1:0] ptrSel;
    logic [2:0] bitSel;
    logic [4:0] rd;
    opc_t       opc;
  } cmd_t;

  typedef enum logic [1:0] {ST_IDLE, ST_EXEC1, ST_EXEC2} state_t;

endpackage

`default_nettype wire

/* rtl/shift_unit.sv */
// Shift and rotate datapath with its flag results
`default_nettype none

module shift_unit
  import bit_flag_load_pkg::*;
(
  input  wire logic [4:0] opc,
  input  wire logic [7:0] val,
  input  wire logic       carryIn,
  output logic      [7:0] res,
  output logic            carryOut,
  output logic            zeroOut,
  output logic            negOut,
  output logic            ovfOut
);

  always_comb
  begin
    res      = val;
    carryOut = carryIn;
    unique case (opc)
      OPC_SHL:
      begin
        res      = {val[6:0], 1'b0};
        carryOut = val[7];
      end
      OPC_SHR:
      begin
        res      = {1'b0, val[7:1]};
        carryOut = val[0];
      end
      OPC_ROTL:
      begin
        res      = {val[6:0], carryIn};
        carryOut = val[7];
      end
      OPC_ROTR:
      begin
        res      = {carryIn, val[7:1]};
        carryOut = val[0];
      end
      OPC_ASHR:
      begin
        res      = {val[7], val[7:1]};
        carryOut = val[0];
      end
      default:
      begin
        res      = val;
        carryOut = carryIn;
      end
    endcase
    zeroOut = (res == 8'h00);
    negOut  = res[7];
    ovfOut  = res[7] ^ carryOut;
  end

endmodule

`default_nettype wire

/* verif/data_mem_model.sv */
// Byte-wide data memory that answers each read strobe one cycle later
`default_nettype none

module data_mem_model
(
  input  wire logic        mclk,
  input  wire logic [15:0] memAddr,
  input  wire logic        memRdEn,
  output logic      [7:0]  memRdData
);
  timeunit 1ns;
  timeprecision 1ps;

  initial memRdData = 8'h3C;

  // Byte mixes both address halves; idle cycles show the inverse
  always @(posedge mclk)
  begin
    if (memRdEn)
      memRdData <= memAddr[15:8] ^ memAddr[7:0] ^ 8'hA5;
    else
      memRdData <= ~memRdData;
  end
endmodule

`default_nettype wire

/* verif/bit_flag_load_exec_properties.sv */
// Concurrent port checks for the execution unit
`default_nettype none

module bit_flag_load_exec_properties
(
  input wire logic        mclk,
  input wire logic        resetn,
  input wire logic        awready,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  input wire logic        memRdEn,
  input wire logic        busy
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  AST_RD_PULSE: assert property (memRdEn |=> !memRdEn)
    else $error("read strobe too long");
  AST_LOAD_LEN: assert property (memRdEn |-> busy ##1 busy ##1 !busy)
    else $error("load length wrong");
  AST_RD_IN_EXEC: assert property (!busy |-> !memRdEn)
    else $error("read strobe while idle");
  AST_BUSY_LEN: assert property ($rose(busy) |-> ##[1:2] !busy)
    else $error("command too long");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read data dropped");
  AST_W_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during response");
  AST_R_BLOCK: assert property (rvalid |-> !arready)
    else $error("read taken during data");
  AST_R_ANSWER: assert property (arvalid && arready |-> ##[1:2] rvalid)
    else $error("read not answered");

  C_LOAD: cover property (memRdEn);
  C_TWO: cover property ($rose(busy) ##1 busy);
  C_WRITE: cover property (bvalid && bready);
endmodule

bind bit_flag_load_exec bit_flag_load_exec_properties u_props (
  .mclk(mclk), .resetn(resetn), .awready(awready), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .arvalid(arvalid), .arready(arready), .rdata(rdata),
  .rvalid(rvalid), .rready(rready), .memRdEn(memRdEn), .busy(busy)
);

`default_nettype wire

/* verif/tb_bit_flag_load_exec.sv */
// Self-checking bench for the bit, flag and load execution unit
`default_nettype none

module tb_bit_flag_load_exec import bit_flag_load_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [1:0]  LD_PTR [7]   = '{PTR_X, PTR_Y, PTR_Z, PTR_X, PTR_Z, PTR_Y, PTR_Y};
  localparam logic [1:0]  LD_MODE [7]  = '{MODE_POSTINC, MODE_PREDEC, MODE_DISP, MODE_PREDEC,
                                           MODE_POSTINC, MODE_DISP, MODE_PLAIN};
  localparam logic [5:0]  LD_DISP [7]  = '{6'h00, 6'h00, 6'h3F, 6'h00, 6'h00, 6'h01, 6'h2A};
  localparam logic [15:0] LD_START [7] = '{16'h0120, 16'h0200, 16'h0300, 16'h0100,
                                           16'h02FF, 16'h0410, 16'h0555};
  logic        mclk, resetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, memRdEn, busy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, lastResp;
  logic [15:0] memAddr;
  logic [7:0]  memRdData;
  int          failCount, numChecks, busyCycles;

  bit_flag_load_exec u_dut (
    .mclk(mclk), .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .memAddr(memAddr), .memRdEn(memRdEn), .memRdData(memRdData), .busy(busy)
  );
  data_mem_model u_mem (.mclk(mclk), .memAddr(memAddr), .memRdEn(memRdEn),
                        .memRdData(memRdData));

  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Busy is stable mid-cycle, so count it there
  always @(negedge mclk)
  begin
    if (busy === 1'b1)
      busyCycles++;
  end

  // ------------------------------------------------------------
  // Bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      failCount++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int n;
    n = 0;
    tb = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!tb && n < 64)
    begin
      @(negedge mclk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      tb = bvalid;
      @(posedge mclk);
      if (ta)
        awvalid <= 1'b0;
      if (tw)
        wvalid <= 1'b0;
      n++;
    end
    if (!tb)
      failCount++;
    bready <= 1'b1;
    @(negedge mclk);
    lastResp = bresp;
    @(posedge mclk);
    bready <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    logic ta, tr;
    logic [31:0] d;
    int n;
    n = 0;
    tr = 1'b0;
    araddr <= a;
    arvalid <= 1'b1;
    while (!tr && n < 64)
    begin
      @(negedge mclk);
      ta = arvalid & arready;
      tr = rvalid;
      @(posedge mclk);
      if (ta)
        arvalid <= 1'b0;
      n++;
    end
    if (!tr)
      failCount++;
    rready <= 1'b1;
    @(negedge mclk);
    d = rdata;
    lastResp = rresp;
    @(posedge mclk);
    rready <= 1'b0;
    @(posedge mclk);
    chk(d, exp);
  endtask

  function automatic logic [11:0] ra(logic [4:0] rg, logic [4:0] n);
    return {rg, n, 2'h0};
  endfunction

  function automatic logic [31:0] mk(opc_t o, logic [4:0] r = 5'h00, logic [2:0] b = 3'h0,
      logic [1:0] p = 2'h0, logic [1:0] m = 2'h0, logic [5:0] q = 6'h00, logic [6:0] k = 7'h00);
    return {1'b0, k, 1'b0, q, m, p, b, r, o};
  endfunction

  task automatic exec(input logic [31:0] c, input int cyc);
    int b0, n;
    b0 = busyCycles;
    n = 0;
    wr(CMD_ADDR, c);
    do
    begin
      @(negedge mclk);
      n++;
    end
    while (busy !== 1'b0 && n < 16);
    @(posedge mclk);
    chk(32'(busyCycles - b0), 32'(cyc));
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_branch;
    logic i, tk;
    for (int j = 0; j < 4; j++)
    begin
      i = j[0];
      tk = i ^ j[1];
      wr(FLAGS_ADDR, {24'h0, i, 7'h2A});
      wr(PC_ADDR, 32'h0000_0040);
      chk({30'h0, lastResp}, {30'h0, RESP_OKAY});
      exec(mk(j[1] ? OPC_BR_IRQ_OFF : OPC_BR_IRQ_ON, .k(7'h7D)), tk ? 2 : 1);
      rchk(PC_ADDR, tk ? 32'h0000_003E : 32'h0000_0041);
      rchk(FLAGS_ADDR, {24'h0, i, 7'h2A});
    end
    $display("branch test done");
  endtask

  task automatic t_io;
    wr(FLAGS_ADDR, 32'h0000_00C3);
    wr(ra(IO_REGION, 5'h1F), 32'h0000_005A);
    exec(mk(OPC_IO_SET, 5'h1F, 3'h0), 2);
    exec(mk(OPC_IO_SET, 5'h1F, 3'h1), 2);
    rchk(ra(IO_REGION, 5'h1F), 32'h0000_005B);
    exec(mk(OPC_IO_CLEAR, 5'h1F, 3'h6), 2);
    exec(mk(OPC_IO_CLEAR, 5'h1F, 3'h7), 2);
    rchk(ra(IO_REGION, 5'h1F), 32'h0000_001B);
    rchk(ra(IO_REGION, 5'h1E), 32'h0000_0000);
    rchk(FLAGS_ADDR, 32'h0000_00C3);
    rchk(12'h040, 32'h0000_0000);
    chk({30'h0, lastResp}, {30'h0, RESP_SLVERR});
    wr(12'h044, 32'h0000_0000);
    chk({30'h0, lastResp}, {30'h0, RESP_SLVERR});
    $display("io bit test done");
  endtask

  task automatic t_shift;
    logic [7:0] v, r;
    logic ci, co;
    for (int j = 0; j < 10; j++)
    begin
      ci = j[0];
      v = ci ? 8'h81 : 8'h01;
      wr(ra(WREG_REGION, 5'h07), {24'h0, v});
      wr(FLAGS_ADDR, {24'h0, 7'h78, ci});
      case (j / 2)
        0: {co, r} = {v, 1'b0};
        1: {r, co} = {1'b0, v};
        2: {co, r} = {v, ci};
        3: {r, co} = {ci, v};
        default: {r, co} = {v[7], v};
      endcase
      exec(mk(opc_t'(OPC_SHL + j / 2), 5'h07), 1);
      rchk(ra(WREG_REGION, 5'h07), {24'h0, r});
      rchk(FLAGS_ADDR, {24'h0, 4'hF, r[7] ^ co, r[7], r == 8'h00, co});
    end
    $display("shift test done");
  endtask

  task automatic t_bit;
    wr(ra(WREG_REGION, 5'h03), 32'h0000_0020);
    wr(FLAGS_ADDR, 32'h0000_00AF);
    exec(mk(OPC_BIT_TO_T, 5'h03, 3'h5), 1);
    rchk(FLAGS_ADDR, 32'h0000_00EF);
    exec(mk(OPC_T_TO_BIT, 5'h04, 3'h7), 1);
    rchk(ra(WREG_REGION, 5'h04), 32'h0000_0080);
    exec(mk(OPC_BIT_TO_T, 5'h03, 3'h0), 1);
    exec(mk(OPC_T_TO_BIT, 5'h03, 3'h5), 1);
    rchk(ra(WREG_REGION, 5'h03), 32'h0000_0000);
    rchk(FLAGS_ADDR, 32'h0000_00AF);
    $display("bit transfer test done");
  endtask

  task automatic t_flag;
    for (int s = 0; s < 8; s++)
    begin
      wr(FLAGS_ADDR, 32'h0000_0000);
      exec(mk(OPC_FLAG_ONE, 5'h00, 3'(s)), 1);
      rchk(FLAGS_ADDR, 32'h1 << s);
      wr(FLAGS_ADDR, 32'h0000_00FF);
      exec(mk(OPC_FLAG_ZERO, 5'h00, 3'(s)), 1);
      rchk(FLAGS_ADDR, 32'h0000_00FF ^ (32'h1 << s));
    end
    rchk(STATUS_ADDR, 32'h0000_7F00);
    $display("flag test done");
  endtask

  task automatic t_load;
    logic [15:0] a, e;
    logic [4:0] lo;
    wr(FLAGS_ADDR, 32'h0000_005A);
    for (int j = 0; j < 7; j++)
    begin
      lo = PTR_LO_BASE + {2'h0, LD_PTR[j], 1'b0};
      wr(ra(WREG_REGION, lo), {24'h0, LD_START[j][7:0]});
      wr(ra(WREG_REGION, lo + 5'h01), {24'h0, LD_START[j][15:8]});
      a = LD_START[j];
      if (LD_MODE[j] == MODE_PREDEC)
        a = a - 16'h0001;
      if (LD_MODE[j] == MODE_DISP)
        a = a + {10'h000, LD_DISP[j]};
      e = (LD_MODE[j] == MODE_POSTINC) ? LD_START[j] + 16'h0001 :
          (LD_MODE[j] == MODE_PREDEC) ? a : LD_START[j];
      exec(mk(OPC_LOAD, 5'h02, 3'h0, LD_PTR[j], LD_MODE[j], LD_DISP[j]), 2);
      rchk(ra(WREG_REGION, 5'h02), {24'h0, a[15:8] ^ a[7:0] ^ 8'hA5});
      rchk(ra(WREG_REGION, lo), {24'h0, e[7:0]});
      rchk(ra(WREG_REGION, lo + 5'h01), {24'h0, e[15:8]});
    end
    rchk(FLAGS_ADDR, 32'h0000_005A);
    $display("load test done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", numChecks, failCount);
    if (failCount == 0 && numChecks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  initial
  begin
    #(25 * 20000);
    failCount++;
    wrap_up;
  end

  initial
  begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wdata} = 56'h0;
    wstrb = 4'hF;
    lastResp = 2'h0;
    {failCount, numChecks, busyCycles} = {32'h0, 32'h0, 32'h0};
    repeat (20) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rchk(FLAGS_ADDR, {24'h0, FLAGS_RESET});
    t_branch;
    t_io;
    t_shift;
    t_bit;
    t_flag;
    t_load;
    wrap_up;
  end
endmodule

`default_nettype wire
